// file: hdl/cce_pkg.sv
// package: register map, field layout and constants of the checksum engine
package cce_pkg;

  // register byte offsets on the avalon slave
  localparam logic [3:0]  OFS_CTRL      = 4'h0;
  localparam logic [3:0]  OFS_INPUT     = 4'h4;
  localparam logic [3:0]  OFS_DATA      = 4'h8;
  localparam logic [3:0]  OFS_FLIP      = 4'hC;

  // control register field positions
  localparam int          CTRL_PTR_LSB  = 0;
  localparam int          CTRL_VAL_BIT  = 2;
  localparam int          CTRL_INIT_BIT = 3;
  localparam int          CTRL_SEL_BIT  = 4;

  // generator polynomials, the 32-bit one in reflected form
  localparam logic [15:0] POLY16        = 16'h1021;
  localparam logic [31:0] POLY32_REFL   = 32'hEDB8_8320;

  // start values selectable by the init value select bit
  localparam logic [31:0] INIT_ZEROS    = 32'h0000_0000;
  localparam logic [31:0] INIT_ONES     = 32'hFFFF_FFFF;

  // reset values
  localparam logic        SEL_RESET     = 1'h0;
  localparam logic        VAL_RESET     = 1'h0;
  localparam logic [1:0]  PTR_RESET     = 2'h0;
  localparam logic [7:0]  FLIP_RESET    = 8'h00;
  localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

  // bus handshake phase
  typedef enum logic [1:0] {
    CCE_PH_IDLE = 2'b01,
    CCE_PH_ACK  = 2'b10
  } cce_phase_e;

  // software visible configuration
  typedef struct packed {
    logic       poly_width_select;
    logic       init_value_select;
    logic [1:0] result_byte_pointer;
  } cce_ctrl_s;

  // whole state of the engine
  typedef struct packed {
    cce_phase_e  phase;
    logic        busy;
    cce_ctrl_s   ctrl;
    logic [31:0] crc;
    logic [7:0]  flip;
    logic [31:0] rdata;
  } cce_state_s;

  localparam cce_state_s STATE_RESET = '{
    phase : CCE_PH_IDLE,
    busy  : 1'h1,
    ctrl  : '{SEL_RESET, VAL_RESET, PTR_RESET},
    crc   : INIT_ZEROS,
    flip  : FLIP_RESET,
    rdata : RDATA_RESET
  };

endpackage : cce_pkg

// file: hdl/cce_crc_step.sv
// combinational fold of one byte into the running checksum
`timescale 1ns/1ns
`default_nettype none
module cce_crc_step (
  input  wire logic [31:0] crc_in,
  input  wire logic [7:0]  byte_in,
  input  wire logic        width16_in,
  output logic [31:0]      crc_out
);

  // all eight bit steps unrolled so a byte completes in one clock
  always_comb begin : fold
    logic [15:0] acc16;
    logic [31:0] acc32;
    acc16 = crc_in[15:0] ^ {byte_in, 8'h00}; // RQ6
    acc32 = crc_in ^ {24'h00_0000, byte_in}; // RQ10
    for (int i = 0; i < 8; i++) begin // RQ8 RQ12 RQ18
      // msb first, shift left, subtract poly when bit 15 was set
      if (acc16[15]) begin
        acc16 = {acc16[14:0], 1'b0} ^ cce_pkg::POLY16; // RQ5
      end else begin
        acc16 = {acc16[14:0], 1'b0};
      end
      // reflected: note bit 0, shift right, subtract reflected poly
      if (acc32[0]) begin
        acc32 = {1'b0, acc32[31:1]} ^ cce_pkg::POLY32_REFL; // RQ9 RQ13
      end else begin
        acc32 = {1'b0, acc32[31:1]};
      end
    end
    // upper half is left alone in 16-bit mode
    crc_out = width16_in ? {crc_in[31:16], acc16} : acc32; // RQ2
  end

endmodule : cce_crc_step
`default_nettype wire

// file: hdl/cce_bit_flip.sv
// bit order reversal of a word
`timescale 1ns/1ns
`default_nettype none
module cce_bit_flip #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] word_in,
  output logic [W-1:0]      word_out
);

  // a zero-width word has nothing to reverse
  if (W < 1) begin : g_bad_w
    $error("cce_bit_flip: W must be at least 1");
  end

  // bit i swaps with bit W-1-i
  always_comb begin
    for (int i = 0; i < W; i++) begin
      word_out[i] = word_in[W-1-i]; // RQ19
    end
  end

endmodule : cce_bit_flip
`default_nettype wire

// file: hdl/cce_engine.sv
// byte-serial crc16/crc32 checksum engine with an avalon-mm slave
//
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// RQ1: bytes written to input port are folded
// RQ2: checksum width 16 or 32 bits
// RQ3: checksum reached only via pointer and data
// RQ4: separate bit reverse register present
// RQ5: 16-bit mode msb first, poly 0x1021
// RQ6: 16-bit byte xored into upper half
// RQ7: 16-bit start value zeros or ones
// RQ8: 16-bit eight left shift steps
// RQ9: 32-bit reflected poly 0x04C11DB7
// RQ10: 32-bit byte xored into low byte
// RQ11: 32-bit start value zeros or ones
// RQ12: 32-bit eight right shifts, poly 0xEDB88320
// RQ13: known 32-bit vectors from all ones
// RQ14: width select 0 is 32, 1 is 16
// RQ15: init strobe loads zeros or ones
// RQ16: pointer selects byte, increments per access
// RQ17: update automatic after each input byte
// RQ18: byte finished before next access
// RQ19: reverse read swaps bit i with 7-i
module cce_engine #(
  parameter int ADDR_W = 4
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out
);

  // the register map needs at least the four byte offsets
  if (ADDR_W < 4) begin : g_bad_addr_w
    $error("cce_engine: ADDR_W must be at least 4");
  end

  cce_pkg::cce_state_s s_r;
  cce_pkg::cce_state_s s_nxt;

  logic        req;
  logic        hs;
  logic        sel_ctrl;
  logic        sel_input;
  logic        sel_data;
  logic        sel_flip;
  logic        wr_lane0;
  logic [31:0] crc_folded;
  logic [7:0]  flip_rev;
  logic [7:0]  crc_byte;
  logic [31:0] rd_mux;
  logic        init_wr;
  logic        init_val;

  // address decode against full byte addresses
  always_comb begin
    sel_ctrl  = avs_address_in == ADDR_W'(cce_pkg::OFS_CTRL);
    sel_input = avs_address_in == ADDR_W'(cce_pkg::OFS_INPUT);
    sel_data  = avs_address_in == ADDR_W'(cce_pkg::OFS_DATA);
    sel_flip  = avs_address_in == ADDR_W'(cce_pkg::OFS_FLIP);
  end

  // a request completes at the edge where waitrequest is seen low
  assign req      = avs_read_in | avs_write_in;
  assign hs       = req & (s_r.phase == cce_pkg::CCE_PH_ACK);
  assign wr_lane0 = hs & avs_write_in & avs_byteenable_in[0];
  assign init_wr  = wr_lane0 & sel_ctrl &
                    avs_writedata_in[cce_pkg::CTRL_INIT_BIT];
  assign init_val = avs_writedata_in[cce_pkg::CTRL_VAL_BIT];

  // folds the written byte into the present checksum in one cycle
  cce_crc_step u_step (
    .crc_in     (s_r.crc),
    .byte_in    (avs_writedata_in[7:0]),
    .width16_in (s_r.ctrl.poly_width_select),
    .crc_out    (crc_folded)
  );

  // the reverse helper is just wiring; the stored byte is the state
  cce_bit_flip #(
    .W (8)
  ) u_flip (
    .word_in  (s_r.flip),
    .word_out (flip_rev)
  );

  // byte of the hidden checksum that the pointer targets
  always_comb begin
    unique case (s_r.ctrl.result_byte_pointer) // RQ16
      2'h0:    crc_byte = s_r.crc[7:0];
      2'h1:    crc_byte = s_r.crc[15:8];
      2'h2:    crc_byte = s_r.crc[23:16];
      default: crc_byte = s_r.crc[31:24];
    endcase
  end

  // read data; the input port and unmapped addresses read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_mux[cce_pkg::CTRL_SEL_BIT] = s_r.ctrl.poly_width_select;
      rd_mux[cce_pkg::CTRL_VAL_BIT] = s_r.ctrl.init_value_select;
      rd_mux[cce_pkg::CTRL_PTR_LSB +: 2] = s_r.ctrl.result_byte_pointer;
    end else if (sel_data) begin
      rd_mux[7:0] = crc_byte; // RQ3
    end else if (sel_flip) begin
      rd_mux[7:0] = flip_rev; // RQ4 RQ19
    end
  end

  // next state: handshake phase plus register side effects
  always_comb begin
    s_nxt = s_r;
    unique case (s_r.phase)
      cce_pkg::CCE_PH_IDLE: begin
        // capture read data now so it stands while waitrequest is low
        if (req) begin
          s_nxt.phase = cce_pkg::CCE_PH_ACK;
          s_nxt.busy  = 1'b0;
          s_nxt.rdata = avs_read_in ? rd_mux : s_r.rdata;
        end
      end
      cce_pkg::CCE_PH_ACK: begin
        s_nxt.phase = cce_pkg::CCE_PH_IDLE;
        s_nxt.busy  = 1'b1;
        if (wr_lane0 && sel_ctrl) begin
          s_nxt.ctrl.poly_width_select =
            avs_writedata_in[cce_pkg::CTRL_SEL_BIT]; // RQ14
          s_nxt.ctrl.init_value_select = init_val;
          s_nxt.ctrl.result_byte_pointer =
            avs_writedata_in[cce_pkg::CTRL_PTR_LSB +: 2];
        end
        // the strobe uses the value select written alongside it
        if (init_wr) begin
          s_nxt.crc = init_val ? cce_pkg::INIT_ONES
                               : cce_pkg::INIT_ZEROS; // RQ7 RQ11 RQ15
        end
        if (wr_lane0 && sel_input) begin
          s_nxt.crc = crc_folded; // RQ1 RQ17 RQ18
        end
        if (wr_lane0 && sel_flip) begin
          s_nxt.flip = avs_writedata_in[7:0]; // RQ4
        end
        // the data port overwrites the selected checksum byte
        if (wr_lane0 && sel_data) begin
          unique case (s_r.ctrl.result_byte_pointer)
            2'h0:    s_nxt.crc[7:0]   = avs_writedata_in[7:0];
            2'h1:    s_nxt.crc[15:8]  = avs_writedata_in[7:0];
            2'h2:    s_nxt.crc[23:16] = avs_writedata_in[7:0];
            default: s_nxt.crc[31:24] = avs_writedata_in[7:0];
          endcase
        end
        // every read or write of the data port steps the pointer
        if (hs && sel_data) begin
          s_nxt.ctrl.result_byte_pointer =
            s_r.ctrl.result_byte_pointer + 2'h1; // RQ16
        end
      end
      default: begin
        // illegal phase code: recover to a clean idle
        s_nxt.phase = cce_pkg::CCE_PH_IDLE;
        s_nxt.busy  = 1'b1;
      end
    endcase
  end

  // single state register
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s_r <= cce_pkg::STATE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata_out    = s_r.rdata;
  assign avs_waitrequest_out = s_r.busy;

  // ---- checks ----
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  logic fold_wr;
  assign fold_wr = wr_lane0 & sel_input;

  // helpers: no register decoded, and a read taken from idle
  logic sel_none;
  logic rd_take;
  assign sel_none = ~(sel_ctrl | sel_input | sel_data | sel_flip);
  assign rd_take  = avs_read_in & (s_r.phase == cce_pkg::CCE_PH_IDLE);

  // known vectors, one fold each from a fixed start value
  AST_VEC32_63: assert property ( // RQ13
    (fold_wr && !s_r.ctrl.poly_width_select &&
     s_r.crc == 32'hFFFF_FFFF && avs_writedata_in[7:0] == 8'h63)
    |=> s_r.crc == 32'hF946_2090)
    else $error("crc32 of 0x63 from all ones is wrong");

  AST_CRC32_STEP: assert property ( // RQ12
    (fold_wr && !s_r.ctrl.poly_width_select &&
     s_r.crc == 32'h0000_0000 && avs_writedata_in[7:0] == 8'h01)
    |=> s_r.crc == 32'h7707_3096)
    else $error("crc32 of 0x01 from zero is wrong");

  AST_CRC16_POLY: assert property ( // RQ5
    (fold_wr && s_r.ctrl.poly_width_select &&
     s_r.crc[15:0] == 16'h0000 && avs_writedata_in[7:0] == 8'h01)
    |=> s_r.crc[15:0] == 16'h1021)
    else $error("crc16 of 0x01 from zero is not the poly");

  AST_HIGH_KEPT16: assert property ( // RQ14
    (fold_wr && s_r.ctrl.poly_width_select)
    |=> s_r.crc[31:16] == $past(s_r.crc[31:16]))
    else $error("16-bit fold disturbed the upper half");

  AST_INIT_LOAD: assert property ( // RQ15
    init_wr |=> s_r.crc == ($past(init_val) ? 32'hFFFF_FFFF
                                             : 32'h0000_0000))
    else $error("init strobe loaded the wrong value");

  AST_PTR_STEP: assert property ( // RQ16
    (hs && sel_data) |=> s_r.ctrl.result_byte_pointer ==
      $past(s_r.ctrl.result_byte_pointer) + 2'h1)
    else $error("result pointer did not step");

  AST_CRC_QUIET: assert property ( // RQ17
    !(hs && avs_write_in) |=> $stable(s_r.crc))
    else $error("checksum changed without a write");

  AST_ONE_WAIT: assert property ( // RQ18
    (req && s_r.phase == cce_pkg::CCE_PH_IDLE)
    |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("waitrequest did not pulse low for one cycle");

  AST_DATA_READ: assert property ( // RQ3
    (avs_read_in && sel_data && s_r.phase == cce_pkg::CCE_PH_IDLE)
    |=> avs_readdata_out == {24'h00_0000, $past(crc_byte)})
    else $error("data port read returned the wrong byte");

  AST_FLIP_READ: assert property ( // RQ19
    (avs_read_in && sel_flip && s_r.phase == cce_pkg::CCE_PH_IDLE)
    |=> avs_readdata_out[7:0] == {$past(s_r.flip[0]),
      $past(s_r.flip[1]), $past(s_r.flip[2]), $past(s_r.flip[3]),
      $past(s_r.flip[4]), $past(s_r.flip[5]), $past(s_r.flip[6]),
      $past(s_r.flip[7])})
    else $error("bit reverse read is not reversed");

  // a 16-bit checksum of all ones folds 0x63 to a known value
  AST_VEC16_63: assert property ( // RQ7
    (fold_wr && s_r.ctrl.poly_width_select &&
     s_r.crc[15:0] == 16'hFFFF && avs_writedata_in[7:0] == 8'h63)
    |=> s_r.crc[15:0] == 16'hBD35)
    else $error("crc16 of 0x63 from all ones is wrong");

  // waitrequest stays high while the slave is idle and unasked
  AST_WAIT_IDLE: assert property ( // RQ18
    (s_r.phase == cce_pkg::CCE_PH_IDLE && !req) |=> avs_waitrequest_out)
    else $error("waitrequest dropped without a request");

  // an access phase always returns to idle on the next edge
  AST_ACK_RETURN: assert property ( // RQ18
    (s_r.phase == cce_pkg::CCE_PH_ACK)
    |=> s_r.phase == cce_pkg::CCE_PH_IDLE)
    else $error("access phase did not return to idle");

  // a control write lands all three fields
  AST_CTRL_WRITE: assert property ( // RQ14
    (wr_lane0 && sel_ctrl) |=>
      s_r.ctrl.poly_width_select ==
        $past(avs_writedata_in[cce_pkg::CTRL_SEL_BIT]) &&
      s_r.ctrl.init_value_select ==
        $past(avs_writedata_in[cce_pkg::CTRL_VAL_BIT]) &&
      s_r.ctrl.result_byte_pointer ==
        $past(avs_writedata_in[cce_pkg::CTRL_PTR_LSB +: 2]))
    else $error("control write did not land");

  // the bit reverse port stores the low byte of a write
  AST_FLIP_STORE: assert property ( // RQ4
    (wr_lane0 && sel_flip) |=> s_r.flip == $past(avs_writedata_in[7:0]))
    else $error("bit reverse byte not stored");

  // a data port write replaces the byte that the pointer chose
  AST_DATA_WRITE: assert property ( // RQ3
    (wr_lane0 && sel_data) |=>
      s_r.crc[8*$past(s_r.ctrl.result_byte_pointer) +: 8] ==
        $past(avs_writedata_in[7:0]))
    else $error("data port write missed its byte");

  // a write without byte lane 0, other than to the data port, leaves checksum, control and flip alone
  AST_LANE0_ONLY: assert property ( // RQ1
    (hs && avs_write_in && !avs_byteenable_in[0] && !sel_data) |=>
      $stable(s_r.crc) && $stable(s_r.ctrl) && $stable(s_r.flip))
    else $error("write without byte lane 0 had an effect");

  // writes to the flip port or to holes never reach the checksum
  AST_FOLD_SOURCE: assert property ( // RQ17
    (hs && avs_write_in && (sel_flip || sel_none)) |=> $stable(s_r.crc))
    else $error("checksum changed on a non-checksum write");

  // read data stand until the next read is taken
  AST_RDATA_HOLD: assert property ( // RQ3
    !rd_take |=> $stable(avs_readdata_out))
    else $error("read data changed without a read");

  // the input port and unmapped addresses read as zero
  AST_ZERO_READ: assert property ( // RQ3
    (rd_take && (sel_input || sel_none)) |=>
      avs_readdata_out == 32'h0000_0000)
    else $error("input port or hole did not read zero");

  // control reads show the fields; the init strobe reads zero
  AST_CTRL_READ: assert property ( // RQ14
    (rd_take && sel_ctrl) |=>
      avs_readdata_out[cce_pkg::CTRL_SEL_BIT] ==
        $past(s_r.ctrl.poly_width_select) &&
      avs_readdata_out[cce_pkg::CTRL_VAL_BIT] ==
        $past(s_r.ctrl.init_value_select) &&
      avs_readdata_out[cce_pkg::CTRL_PTR_LSB +: 2] ==
        $past(s_r.ctrl.result_byte_pointer) &&
      !avs_readdata_out[cce_pkg::CTRL_INIT_BIT])
    else $error("control read returned wrong fields");

  // the pointer moves only on data port accesses and control writes
  AST_PTR_HOLD: assert property ( // RQ16
    (!(hs && sel_data) && !(wr_lane0 && sel_ctrl)) |=>
      $stable(s_r.ctrl.result_byte_pointer))
    else $error("result pointer moved on its own");

  // covers of the main scenarios
  COV_FOLD32: cover property (fold_wr && !s_r.ctrl.poly_width_select);
  COV_FOLD16: cover property (fold_wr && s_r.ctrl.poly_width_select);
  COV_INIT:   cover property (init_wr);
  COV_RD_DAT: cover property (hs && avs_read_in && sel_data);
  COV_RD_FLP: cover property (hs && avs_read_in && sel_flip);

endmodule : cce_engine
`default_nettype wire

// file: dv/cce_bus_master.sv
// bus master model standing in for the processor side of the engine
`timescale 1ns/1ns
`default_nettype none
module cce_bus_master (
  input  wire logic        clk_sys_in,
  input  wire logic [31:0] readdata_in,
  input  wire logic        waitrequest_in,
  output logic      [3:0]  address_out,
  output logic             read_out,
  output logic             write_out,
  output logic      [31:0] writedata_out,
  output logic      [3:0]  byteenable_out
);
  // idle bus at time zero
  initial begin
    address_out    = 4'h0;
    read_out       = 1'b0;
    write_out      = 1'b0;
    writedata_out  = 32'h0000_0000;
    byteenable_out = 4'h0;
  end

  // one access, held until waitrequest is sampled low; a slave that
  // never answers is left to the bench watchdog
  task automatic xfer(input logic [3:0] a, input logic rd,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
    address_out    <= a;
    read_out       <= rd;
    write_out      <= ~rd;
    writedata_out  <= d;
    byteenable_out <= be;
    do begin
      @(posedge clk_sys_in);
    end while (waitrequest_in !== 1'b0);
    q = readdata_in;
    read_out       <= 1'b0;
    write_out      <= 1'b0;
    writedata_out  <= ~d;  // released data never keeps the old value
    // one idle edge so the next request is a fresh assignment
    @(posedge clk_sys_in);
  endtask : xfer
endmodule : cce_bus_master
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench of the byte-serial checksum engine
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk_sys_in = 1'b0;
  logic        rst_in     = 1'b1;
  logic [3:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [3:0]  be;
  logic        waitreq;
  logic [31:0] q;
  int          n_mismatch = 0;
  int          n_tests    = 0;

  // 125 MHz system clock
  always #4 clk_sys_in = ~clk_sys_in;

  cce_engine #(.ADDR_W(4)) i_cce_engine (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_byteenable_in(be), .avs_readdata_out(rdat),
    .avs_waitrequest_out(waitreq));

  cce_bus_master i_cce_bus_master (
    .clk_sys_in(clk_sys_in), .readdata_in(rdat), .waitrequest_in(waitreq),
    .address_out(adr), .read_out(rd), .write_out(wr),
    .writedata_out(wdat), .byteenable_out(be));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    i_cce_bus_master.xfer(a, 1'b0, {24'h00_0000, d}, 4'hF, q);
  endtask : wrr

  task automatic rdd(input logic [3:0] a, output logic [31:0] v);
    i_cce_bus_master.xfer(a, 1'b1, 32'h0000_0000, 4'hF, v);
  endtask : rdd

  // pointer back to byte 0, then four data port reads low to high
  task automatic rd_crc(input logic sel, output logic [31:0] v);
    wrr(4'h0, {3'h0, sel, 4'h0});
    for (int i = 0; i < 4; i++) begin
      rdd(4'h8, q);
      v[8*i +: 8] = q[7:0];
    end
  endtask : rd_crc

  // bench reference fold; 16-bit mode leaves the upper half alone
  function automatic logic [31:0] fold(logic [31:0] c, logic [7:0] b,
                                       logic w16);
    if (w16) c[15:8] = c[15:8] ^ b;
    else c[7:0] = c[7:0] ^ b;
    for (int i = 0; i < 8; i++)
      if (w16) c[15:0] = {c[14:0], 1'b0} ^ (c[15] ? 16'h1021 : 16'h0000);
      else c = (c >> 1) ^ (c[0] ? 32'hEDB8_8320 : 32'h0000_0000);
    return c;
  endfunction : fold

  // init, fold a byte list, read the result back
  task automatic run(input logic sel, input logic val,
                     input logic [7:0] s[$], output logic [31:0] v);
    wrr(4'h0, {3'h0, sel, 1'b1, val, 2'h0});
    foreach (s[i]) wrr(4'h4, s[i]);
    rd_crc(sel, v);
  endtask : run

  task automatic t_reset;
    rdd(4'h0, q);
    chk(q, 32'h0000_0000);
    rd_crc(1'b0, q);
    chk(q, 32'h0000_0000);
  endtask : t_reset

  task automatic t_crc32;
    run(1'b0, 1'b1, '{8'h63}, q);
    chk(q, 32'hF946_2090);
    run(1'b0, 1'b1, '{8'hAA, 8'hBB, 8'hCC}, q);
    chk(q, 32'h41B2_07B3);
    run(1'b0, 1'b1, '{8'h00, 8'h00, 8'hAA, 8'hBB, 8'hCC}, q);
    chk(q, 32'h78D1_29BC);
    run(1'b0, 1'b0, '{8'h01}, q);
    chk(q, 32'h7707_3096);
  endtask : t_crc32

  // 16-bit vectors from all ones and one from zero; the upper half keeps the init value
  task automatic t_crc16;
    run(1'b1, 1'b1, '{8'h63}, q);
    chk(q, 32'hFFFF_BD35);
    run(1'b1, 1'b1, '{8'h8C}, q);
    chk(q, 32'hFFFF_B1F4);
    run(1'b1, 1'b1, '{8'h7D}, q);
    chk(q, 32'hFFFF_4ECA);
    run(1'b1, 1'b1, '{8'hAA, 8'hBB, 8'hCC}, q);
    chk(q, 32'hFFFF_6CF6);
    run(1'b1, 1'b1, '{8'h00, 8'h00, 8'hAA, 8'hBB, 8'hCC}, q);
    chk(q, 32'hFFFF_B166);
    run(1'b1, 1'b0, '{8'h01}, q);
    chk(q, 32'h0000_1021);
    rdd(4'h0, q);
    chk(q, 32'h0000_0010);
  endtask : t_crc16

  // data port writes start at byte 2 and wrap, then a fold follows
  task automatic t_data;
    wrr(4'h0, 8'h02);
    rdd(4'h0, q);
    chk(q, 32'h0000_0002);
    for (int i = 0; i < 4; i++) wrr(4'h8, 8'hA5 ^ (8'h11 * 8'(i)));
    rdd(4'h0, q);
    chk(q, 32'h0000_0002);
    rd_crc(1'b0, q);
    chk(q, 32'hB4A5_9687);
    wrr(4'h4, 8'h42);
    rd_crc(1'b0, q);
    chk(q, fold(32'hB4A5_9687, 8'h42, 1'b0));
  endtask : t_data

  task automatic t_flip;
    wrr(4'hC, 8'h01);
    rdd(4'hC, q);
    chk(q, 32'h0000_0080);
    wrr(4'hC, 8'hC4);
    rdd(4'hC, q);
    chk(q, 32'h0000_0023);
  endtask : t_flip

  // unmapped address and a write with byte 0 disabled change nothing
  task automatic t_refused;
    wrr(4'h0, 8'h08);
    wrr(4'h2, 8'h55);
    rdd(4'h2, q);
    chk(q, 32'h0000_0000);
    rdd(4'h4, q);
    chk(q, 32'h0000_0000);
    i_cce_bus_master.xfer(4'h4, 1'b0, 32'h0000_0055, 4'hE, q);
    rd_crc(1'b0, q);
    chk(q, 32'h0000_0000);
  endtask : t_refused

  task automatic end_of_test;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // main sequence after ten cycles of reset
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    t_reset();
    t_crc32();
    t_crc16();
    t_data();
    t_flip();
    t_refused();
    end_of_test();
  end

  // watchdog: the tests need a few hundred cycles at most
  initial begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
